// *** rtl/aarr_pkg.sv ***
package aarr_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned RES_W     = 16;
  localparam int unsigned NUM_PAIRS = 4;
  localparam int unsigned IDX_W     = 14;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SUPPLY_HI = 14'h05c0;
  localparam logic [IDX_W-1:0] IDX_SUPPLY_LO = 14'h05c1;
  localparam logic [IDX_W-1:0] IDX_HLIM_HI   = 14'h05c2;
  localparam logic [IDX_W-1:0] IDX_HLIM_LO   = 14'h05c3;
  localparam logic [IDX_W-1:0] IDX_LLIM_HI   = 14'h05c4;
  localparam logic [IDX_W-1:0] IDX_LLIM_LO   = 14'h05c5;
  localparam logic [IDX_W-1:0] IDX_HEAT_HI   = 14'h05c6;
  localparam logic [IDX_W-1:0] IDX_HEAT_LO   = 14'h05c7;
  localparam logic [IDX_W-1:0] IDX_CONFIG    = 14'h05f0;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 14'h05f1;

  // Result pair numbering
  localparam logic [1:0] CH_SUPPLY = 2'h0;
  localparam logic [1:0] CH_HLIM   = 2'h1;
  localparam logic [1:0] CH_LLIM   = 2'h2;
  localparam logic [1:0] CH_HEAT   = 2'h3;

  // Reset values
  localparam logic [BYTE_W-1:0] RESET_HI   = 8'h80;
  localparam logic [BYTE_W-1:0] RESET_LO   = 8'h00;
  localparam logic              RESET_HSEL = 1'b0;

  // Field positions
  localparam int unsigned CFG_HSEL_BIT = 0;

  typedef struct packed {
    logic [NUM_PAIRS-1:0][BYTE_W-1:0] hi;
    logic [NUM_PAIRS-1:0][BYTE_W-1:0] lo;
    logic [NUM_PAIRS-1:0]             frz;
    logic                             heat_sel;
    logic                             ack;
    logic                             slverr;
    logic [DATA_W-1:0]                rdata;
  } aarr_state_t;

endpackage : aarr_pkg

// *** rtl/aarr_readout.sv ***
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
// How it works
// - Reading the high-limit high byte freezes its low byte until it is read.
// - Reading the low-limit high byte freezes its low byte until it is read.
// - Reading the heat-limit high byte freezes its low byte until it is read.
// - The high-limit pair holds the converter result of 0.8 times that threshold.
// - The low-limit pair holds the converter result of 0.8 times that threshold.
// - The heat pair takes the ordinary or balance heat result per the select bit.
// - The supply reference low byte reads at index 0x5c1 and resets to zero.
// - The high-limit pair reads high byte at 0x5c2 and low byte at 0x5c3.
// - The low-limit pair reads high byte at 0x5c4 and low byte at 0x5c5.
// - Each high byte resets to 0x80 and each low byte to zero.
// - Reading the supply reference high byte at 0x5c0 freezes its low byte.
module aarr_readout (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_ce,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [aarr_pkg::ADDR_W-1:0] i_paddr,
  input  wire logic [aarr_pkg::DATA_W-1:0] i_pwdata,
  output logic      [aarr_pkg::DATA_W-1:0] o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic                        i_supply_valid,
  input  wire logic [aarr_pkg::RES_W-1:0]  i_supply_data,
  input  wire logic                        i_hlim_valid,
  input  wire logic [aarr_pkg::RES_W-1:0]  i_hlim_data,
  input  wire logic                        i_llim_valid,
  input  wire logic [aarr_pkg::RES_W-1:0]  i_llim_data,
  input  wire logic                        i_heat_valid,
  input  wire logic [aarr_pkg::RES_W-1:0]  i_heat_data,
  input  wire logic                        i_bheat_valid,
  input  wire logic [aarr_pkg::RES_W-1:0]  i_bheat_data,
  output logic                             o_heat_threshold_select
);
  import aarr_pkg::*;

  aarr_state_t                          state_reg;
  aarr_state_t                          state_next;
  logic        [NUM_PAIRS-1:0]          upd_v;
  logic        [NUM_PAIRS-1:0][RES_W-1:0] upd_d;
  logic        [IDX_W-1:0]              idx;
  logic                                 aligned;
  logic                                 in_pairs;
  logic        [1:0]                    pair;
  logic                                 pick_hi;
  logic                                 acc;

  assign idx      = i_paddr[ADDR_W-1:2];
  assign aligned  = (i_paddr[1:0] == 2'h0);
  assign in_pairs = aligned && (idx >= IDX_SUPPLY_HI) && (idx <= IDX_HEAT_LO);
  assign pair     = idx[2:1];
  assign pick_hi  = ~idx[0];
  assign acc      = i_psel && i_penable && !state_reg.ack;

  // Converter inputs; both limit DACs are sampled at 0.8x threshold
  // high-limit source
  assign upd_v[CH_HLIM]   = i_hlim_valid;
  assign upd_d[CH_HLIM]   = i_hlim_data;
  assign upd_v[CH_LLIM]   = i_llim_valid;
  assign upd_d[CH_LLIM]   = i_llim_data;
  assign upd_v[CH_SUPPLY] = i_supply_valid;
  assign upd_d[CH_SUPPLY] = i_supply_data;
  assign upd_v[CH_HEAT] = state_reg.heat_sel ? i_bheat_valid : i_heat_valid;
  assign upd_d[CH_HEAT] = state_reg.heat_sel ? i_bheat_data : i_heat_data;

  always_comb begin
    state_next     = state_reg;
    state_next.ack = acc;
    if (acc) begin
      state_next.slverr = 1'b0;
      state_next.rdata  = '0;
      if (i_pwrite) begin
        // Result bytes are read-only; writes there are dropped silently
        if (aligned && idx == IDX_CONFIG) begin
          state_next.heat_sel = i_pwdata[CFG_HSEL_BIT];
        end else if (!in_pairs && !(aligned && idx == IDX_STATUS)) begin
          state_next.slverr = 1'b1;
        end
      end else if (in_pairs) begin
        if (pick_hi) begin
          state_next.frz[pair] = 1'b1;
          state_next.rdata = {24'h000000, state_reg.hi[pair]};
        end else begin
          state_next.frz[pair] = 1'b0;
          state_next.rdata = {24'h000000, state_reg.lo[pair]};
        end
      end else if (aligned && idx == IDX_CONFIG) begin
        state_next.rdata = {31'h00000000, state_reg.heat_sel};
      end else if (aligned && idx == IDX_STATUS) begin
        state_next.rdata = {28'h0000000, state_reg.frz};
      end else begin
        state_next.slverr = 1'b1;
      end
    end
    // Freeze set this cycle also blocks the low byte, keeping the pair whole
    for (int ch = 0; ch < NUM_PAIRS; ch++) begin
      if (upd_v[ch]) begin
        state_next.hi[ch] = upd_d[ch][RES_W-1:BYTE_W];
        if (!state_next.frz[ch]) begin
          state_next.lo[ch] = upd_d[ch][BYTE_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg.hi       <= {NUM_PAIRS{RESET_HI}};
      state_reg.lo       <= {NUM_PAIRS{RESET_LO}};
      state_reg.frz      <= '0;
      state_reg.heat_sel <= RESET_HSEL;
      state_reg.ack      <= 1'b0;
      state_reg.slverr   <= 1'b0;
      state_reg.rdata    <= '0;
    end else if (i_ce) begin
      state_reg <= state_next;
    end
  end

  // One wait state; gated so a stalled block never completes a transfer
  assign o_pready  = state_reg.ack && i_ce;
  assign o_prdata  = state_reg.rdata;
  assign o_pslverr = state_reg.slverr;
  assign o_heat_threshold_select = state_reg.heat_sel;

  sequence seq_hi_read(logic [IDX_W-1:0] hidx);
    i_ce && acc && !i_pwrite && aligned && idx == hidx;
  endsequence

  sequence seq_lo_read(logic [IDX_W-1:0] lidx);
    i_ce && acc && !i_pwrite && aligned && idx == lidx;
  endsequence

  property p_freeze(logic [IDX_W-1:0] hidx, int ch);
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_hi_read(hidx) |=> state_reg.frz[ch]
        && state_reg.lo[ch] == $past(state_reg.lo[ch]);
  endproperty

  property p_hold(int ch, logic [IDX_W-1:0] lidx);
    @(posedge i_clk) disable iff (!i_rst_n)
      state_reg.frz[ch]
        && !(i_ce && acc && !i_pwrite && aligned && idx == lidx)
        |=> $stable(state_reg.lo[ch]) && state_reg.frz[ch];
  endproperty

  AST_HLIM_FREEZE: assert property (p_freeze(IDX_HLIM_HI, 1))
    else $error("high-limit low byte not frozen after high read");
  AST_HLIM_HOLD: assert property (p_hold(1, IDX_HLIM_LO))
    else $error("high-limit low byte moved while frozen");
  AST_LLIM_FREEZE: assert property (p_freeze(IDX_LLIM_HI, 2))
    else $error("low-limit low byte not frozen after high read");
  AST_HEAT_HOLD: assert property (p_hold(3, IDX_HEAT_LO))
    else $error("heat low byte moved while frozen");
  AST_SUPPLY_FREEZE: assert property (p_freeze(IDX_SUPPLY_HI, 0))
    else $error("supply low byte not frozen after high read");

  AST_HLIM_LOAD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_hlim_valid && !state_next.frz[1]
        |=> state_reg.hi[1] == $past(i_hlim_data[15:8])
          && state_reg.lo[1] == $past(i_hlim_data[7:0]))
    else $error("high-limit pair did not take the converter result");

  AST_LLIM_LOAD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_llim_valid
        |=> state_reg.hi[2] == $past(i_llim_data[15:8]))
    else $error("low-limit high byte did not take the converter result");

  AST_HEAT_SELECT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && state_reg.heat_sel && i_bheat_valid
        |=> state_reg.hi[3] == $past(i_bheat_data[15:8]))
    else $error("heat pair ignored the balance heat source");

  AST_SUPPLY_LO_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_SUPPLY_LO)
        |=> o_prdata == {24'h000000, $past(state_reg.lo[0])} ##1 !o_pready)
    else $error("supply low byte read returned wrong data");

  AST_HLIM_HI_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_hi_read(IDX_HLIM_HI)
        |=> o_prdata[7:0] == $past(state_reg.hi[1]) && !o_pslverr)
    else $error("high-limit high byte read returned wrong data");

  AST_LLIM_LO_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_LLIM_LO)
        |=> o_prdata[7:0] == $past(state_reg.lo[2]) && !o_pslverr)
    else $error("low-limit low byte read returned wrong data");

  AST_RESET_VALUES: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> state_reg.hi == {NUM_PAIRS{RESET_HI}}
        && state_reg.lo == {NUM_PAIRS{RESET_LO}} && !o_pready)
    else $error("result bytes left reset with wrong values");

  AST_RELEASE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_HEAT_LO) |=> !state_reg.frz[3])
    else $error("heat freeze not released by low read");

  AST_LLIM_HOLD: assert property (p_hold(2, IDX_LLIM_LO))
    else $error("low-limit low byte moved while frozen");

  AST_HEAT_FREEZE: assert property (p_freeze(IDX_HEAT_HI, 3))
    else $error("heat low byte not frozen after high read");

  AST_SUPPLY_HOLD: assert property (p_hold(0, IDX_SUPPLY_LO))
    else $error("supply low byte moved while frozen");

  AST_HLIM_RELEASE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_HLIM_LO)
        |=> !state_reg.frz[1])
    else $error("high-limit freeze not released by low read");

  AST_LLIM_RELEASE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_LLIM_LO)
        |=> !state_reg.frz[2])
    else $error("low-limit freeze not released by low read");

  AST_SUPPLY_RELEASE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_SUPPLY_LO)
        |=> !state_reg.frz[0])
    else $error("supply freeze not released by low read");

  AST_HEAT_ORDINARY: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && !state_reg.heat_sel && i_heat_valid
        |=> state_reg.hi[3] == $past(i_heat_data[15:8]))
    else $error("heat pair ignored the ordinary heat source");

  AST_HEAT_IGNORE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && state_reg.heat_sel && !i_bheat_valid
        |=> $stable(state_reg.hi[3]))
    else $error("heat pair took the unselected source");

  AST_SUPPLY_LOAD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_supply_valid && !state_next.frz[0]
        |=> state_reg.lo[0] == $past(i_supply_data[7:0]))
    else $error("supply low byte did not take the converter result");

  AST_HLIM_LO_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_HLIM_LO)
        |=> o_prdata == {24'h000000, $past(state_reg.lo[1])})
    else $error("high-limit low byte read returned wrong data");

  AST_LLIM_HI_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_hi_read(IDX_LLIM_HI)
        |=> o_prdata == {24'h000000, $past(state_reg.hi[2])})
    else $error("low-limit high byte read returned wrong data");

  AST_HEAT_LO_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_lo_read(IDX_HEAT_LO)
        |=> o_prdata == {24'h000000, $past(state_reg.lo[3])})
    else $error("heat low byte read returned wrong data");

  AST_HEAT_HI_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_hi_read(IDX_HEAT_HI)
        |=> o_prdata == {24'h000000, $past(state_reg.hi[3])})
    else $error("heat high byte read returned wrong data");

  AST_SUPPLY_HI_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_hi_read(IDX_SUPPLY_HI)
        |=> o_prdata == {24'h000000, $past(state_reg.hi[0])})
    else $error("supply high byte read returned wrong data");

  AST_PREADY_PULSE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      o_pready
        |=> !o_pready)
    else $error("ready held for more than one cycle");

  AST_CE_HOLD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_ce
        |=> $stable(state_reg))
    else $error("state moved while the clock enable was low");

  AST_HI_TRACKS_FROZEN: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && state_reg.frz[1] && i_hlim_valid
        |=> state_reg.hi[1] == $past(i_hlim_data[15:8]))
    else $error("high-limit high byte stopped while low byte frozen");

  AST_STATUS_READ: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      seq_hi_read(IDX_STATUS)
        |=> o_prdata == {28'h0000000, $past(state_reg.frz)})
    else $error("status read did not show the freeze flags");

  AST_RESET_OUTPUTS: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> !o_heat_threshold_select && state_reg.frz == '0
        && o_prdata == '0 && !o_pslverr)
    else $error("outputs or freezes left reset with wrong values");

  AST_WRITE_RO: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && acc && i_pwrite && in_pairs && !(|upd_v)
        |=> $stable(state_reg.lo) && $stable(state_reg.hi))
    else $error("write changed a read-only result byte");

  AST_SLVERR_ZERO: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      o_pready && o_pslverr
        |-> o_prdata == '0)
    else $error("error response carried nonzero data");

  AST_LLIM_LO_LOAD: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
      i_ce && i_llim_valid && !state_next.frz[2]
        |=> state_reg.lo[2] == $past(i_llim_data[7:0]))
    else $error("low-limit low byte did not take the converter result");

endmodule : aarr_readout

// *** tb/aarr_readout_bench.sv ***
`timescale 1ns/1ps
module aarr_readout_bench;
  import aarr_pkg::*;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              ce = 1'b1;
  logic              psel = 1'b0;
  logic              pen = 1'b0;
  logic              pwr = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic              pready;
  logic              pslverr;
  logic              hsel;
  logic [4:0]        cv = '0;
  logic [RES_W-1:0]  cd [5] = '{default: '0};
  logic [DATA_W-1:0] rd;
  logic              err;
  logic [RES_W-1:0]  v1, v2, v3;
  logic [ADDR_W-1:0] a;
  int                error_cnt = 0;
  int                cmp_count = 0;

  always #10 clk = ~clk;

  aarr_readout i_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_supply_valid(cv[0]), .i_supply_data(cd[0]),
    .i_hlim_valid(cv[1]), .i_hlim_data(cd[1]),
    .i_llim_valid(cv[2]), .i_llim_data(cd[2]),
    .i_heat_valid(cv[3]), .i_heat_data(cd[3]),
    .i_bheat_valid(cv[4]), .i_bheat_data(cd[4]),
    .o_heat_threshold_select(hsel)
  );

  task automatic chk(input logic [DATA_W-1:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Request held until ready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [ADDR_W-1:0] ad,
                     input logic [DATA_W-1:0] wd);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= ad; pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [ADDR_W-1:0] ad, input logic [7:0] exp);
    apb(1'b0, ad, '0);
    chk(rd, {24'h0, exp});
    chk({31'h0, err}, '0);
  endtask : rdc

  task automatic load(input int ch, input logic [RES_W-1:0] v);
    @(posedge clk);
    cv[ch] <= 1'b1; cd[ch] <= v;
    @(posedge clk);
    cv[ch] <= 1'b0;
  endtask : load

  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      rdc(16'(32'h1700 + p * 8), 8'h80);
      rdc(16'(32'h1704 + p * 8), 8'h00);
    end
    chk({31'h0, hsel}, '0);
    for (int p = 0; p < 4; p++) begin
      a = 16'(32'h1700 + p * 8);
      v1 = 16'(32'h1a2a + p * 32'h0101);
      v2 = 16'(32'h3b4b + p * 32'h0101);
      v3 = 16'(32'h5c6c + p * 32'h0101);
      load(p, v1);
      rdc(a, v1[15:8]);
      rdc(16'h17c4, 8'(1 << p));
      load(p, v2);
      rdc(a + 16'h4, v1[7:0]);
      rdc(a, v2[15:8]);
      rdc(a + 16'h4, v1[7:0]);
      rdc(16'h17c4, 8'h00);
      load(p, v3);
      rdc(a + 16'h4, v3[7:0]);
      rdc(a, v3[15:8]);
      rdc(a + 16'h4, v3[7:0]);
    end
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, 16'h17c0, 32'(s));
      chk({31'h0, hsel}, 32'(s));
      rdc(16'h17c0, 8'(s));
      v1 = 16'(32'h7e81 + s * 32'h1111);
      v2 = 16'(32'h2418 + s * 32'h1111);
      load(s ? 4 : 3, v1);
      load(s ? 3 : 4, v2);
      rdc(16'h1718, v1[15:8]);
      rdc(16'h171c, v1[7:0]);
    end
    // Result bytes ignore writes without error
    apb(1'b1, 16'h1708, 32'hff);
    chk({31'h0, err}, '0);
    rdc(16'h1708, 8'h5d);
    apb(1'b0, 16'h1800, '0);
    chk({31'h0, err}, 32'h1);
    chk(rd, '0);
    apb(1'b0, 16'h1702, '0);
    chk({31'h0, err}, 32'h1);
    // Stalled block ignores a converter pulse
    @(posedge clk);
    ce <= 1'b0;
    load(1, 16'h9999);
    @(posedge clk);
    ce <= 1'b1;
    rdc(16'h1708, 8'h5d);
    rdc(16'h170c, 8'h6d);
    // Second reset in mid-run
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc(16'h1708, 8'h80);
    rdc(16'h1704, 8'h00);
    chk({31'h0, hsel}, '0);
    stop_test();
  end
endmodule : aarr_readout_bench
